// [rtl/ppb_port_bank.sv]
// Ten-port parallel I/O bank with keypad edge status on a Wishbone slave
`timescale 1ns/1ns
`default_nettype none
module ppb_port_bank
  import ppb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [6:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [7:0] pin_a_i,
  output logic [7:0] pin_a_o,
  output logic [7:0] pin_a_oe_o,
  input wire logic [7:0] pin_b_i,
  output logic [7:0] pin_b_o,
  output logic [7:0] pin_b_oe_o,
  input wire logic [7:0] pin_c_i,
  output logic [7:0] pin_c_o,
  output logic [7:0] pin_c_oe_o,
  input wire logic [7:0] pin_d_i,
  output logic [7:0] pin_d_o,
  output logic [7:0] pin_d_oe_o,
  input wire logic [7:0] pin_e_i,
  output logic [7:0] pin_e_o,
  output logic [7:0] pin_e_oe_o,
  input wire logic [7:0] pin_f_i,
  output logic [7:0] pin_f_o,
  output logic [7:0] pin_f_oe_o,
  input wire logic [7:0] pin_g_i,
  output logic [7:0] pin_g_o,
  output logic [7:0] pin_g_oe_o,
  output logic [7:0] pin_h_o,
  output logic [7:0] pin_i_o,
  output logic [7:0] pin_j_o,
  output logic [7:0] pin_j_oe_o,
  output logic [7:0] pullup_a_o,
  output logic [7:0] pullup_c_o,
  input wire logic cond_code_mask_i,
  output logic keypad_irq_o,
  input wire logic spi_enable_i,
  input wire logic [3:0] spi_out_i,
  input wire logic [3:0] spi_oe_i,
  output logic [3:0] spi_in_o,
  input wire logic sci_enable_i,
  input wire logic sci_tx_i,
  output logic serial_receive_in_o,
  output logic [3:0] capture_inputs_o,
  input wire logic [1:0] compare_outputs_i,
  input wire logic refresh_clk_i,
  input wire logic [2:0] pulse_outputs_i,
  output logic [7:0] adc_select_o,
  input wire logic [39:0] lcd_frontplane_lines_i
);
  // Latch index 0..6 = ports A..G, out index 0..2 = H..J, control 0..6 = D..J
  logic [7:0] dir_q [0:4];
  logic [7:0] dir_d [0:4];
  logic [7:0] lat_q [0:6];
  logic [7:0] lat_d [0:6];
  logic [7:0] out_q [0:2];
  logic [7:0] out_d [0:2];
  logic [7:0] ctl_q [0:6];
  logic [7:0] ctl_d [0:6];
  logic [5:0] edg_q, edg_d;
  logic key_en_q, key_en_d;
  logic [1:0] opt_q, opt_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [4:0] idx;
  logic req, wr_en, rd_take;
  logic [7:0] wb, rd_val, key_status, key_clr_mask, e_sel, e_special, hij_h, hij_i, hij_j;
  logic key_clr_all, keypad_flag, keymux, pullup_enable;

  // Read value: latch where the pin is an output, else the pin
  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] lat,
                                           input logic [7:0] pin);
    port_view = (dir & lat) | (~dir & pin);
  endfunction

  // Wishbone classic: ack one cycle after the request, write at the acked edge
  assign req = cyc_i && stb_i;
  assign idx = adr_i[6:2];
  assign wb = dat_i[7:0];
  assign wr_en = req && we_i && ack_q && sel_i[0];
  assign rd_take = req && !we_i && !ack_q;
  assign keymux = opt_q[OPT_STATUS_VIEW_BIT];
  assign pullup_enable = opt_q[OPT_PULLUP_BIT];
  assign keypad_flag = |key_status;
  assign key_clr_all = wr_en && (idx == IDX_SYS_OPT) && wb[OPT_CLEAR_ALL_BIT];
  assign key_clr_mask = (wr_en && (idx == IDX_PA_DATA) && keymux) ? wb : 8'h00;

  ppb_key_edge u_key (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(pin_a_i),
    .enable_i(~dir_q[0]),
    .rise_sel_i({2'h0, edg_q}), // Lines 6 and 7 are always falling
    .clear_all_i(key_clr_all),
    .clear_mask_i(key_clr_mask),
    .status_o(key_status)
  );

  // Register read mux
  always_comb begin
    rd_val = 8'h00;
    if (idx == IDX_PA_DATA) begin
      rd_val = keymux ? key_status : port_view(dir_q[0], lat_q[0], pin_a_i);
    end else if (idx == IDX_PB_DATA) begin
      rd_val = port_view(dir_q[1], lat_q[1], pin_b_i);
    end else if (idx == IDX_PC_DATA) begin
      rd_val = port_view(dir_q[2], lat_q[2], pin_c_i);
    end else if (idx == IDX_PD_DATA) begin
      rd_val = port_view(dir_q[3], lat_q[3], pin_d_i) & ~ctl_q[0];
    end else if (idx == IDX_PE_DATA) begin
      rd_val = port_view(dir_q[4], lat_q[4], pin_e_i);
    end else if (idx == IDX_PA_DIR) begin
      rd_val = dir_q[0];
    end else if (idx == IDX_PB_DIR) begin
      rd_val = dir_q[1];
    end else if (idx == IDX_PC_DIR) begin
      rd_val = dir_q[2];
    end else if (idx == IDX_PD_DIR) begin
      rd_val = dir_q[3] & ~ctl_q[0];
    end else if (idx == IDX_PE_DIR) begin
      rd_val = dir_q[4];
    end else if (idx == IDX_PF_DATA) begin
      rd_val = port_view(ctl_q[2], lat_q[5], pin_f_i);
    end else if (idx == IDX_PG_DATA) begin
      rd_val = port_view(ctl_q[3], lat_q[6], pin_g_i);
    end else if (idx == IDX_PH_DATA) begin
      rd_val = out_q[0];
    end else if (idx == IDX_PI_DATA) begin
      rd_val = out_q[1];
    end else if (idx == IDX_PJ_DATA) begin
      rd_val = out_q[2];
    end else if (idx == IDX_PD_CTRL) begin
      rd_val = ctl_q[0];
    end else if (idx == IDX_PE_CTRL) begin
      rd_val = ctl_q[1];
    end else if (idx == IDX_PF_CTRL) begin
      rd_val = ctl_q[2];
    end else if (idx == IDX_PG_CTRL) begin
      rd_val = ctl_q[3];
    end else if (idx == IDX_PH_CTRL) begin
      rd_val = ctl_q[4];
    end else if (idx == IDX_PI_CTRL) begin
      rd_val = ctl_q[5];
    end else if (idx == IDX_PJ_CTRL) begin
      rd_val = ctl_q[6];
    end else if (idx == IDX_KEY_CTRL) begin
      rd_val = {keypad_flag, key_en_q, edg_q};
    end else if (idx == IDX_SYS_OPT) begin
      rd_val = {6'h00, opt_q};
    end
  end

  // Next-state of all software registers
  always_comb begin
    dir_d = dir_q;
    lat_d = lat_q;
    out_d = out_q;
    ctl_d = ctl_q;
    edg_d = edg_q;
    key_en_d = key_en_q;
    opt_d = opt_q;
    ack_d = req && !ack_q;
    dat_d = ack_q ? DAT_RST : dat_q;
    if (rd_take) begin
      dat_d = {24'h000000, rd_val};
    end
    if (wr_en) begin
      // Data writes land in the latch except port A in status view and port D converter bits; direction decides driving on ports A to E
      if (idx == IDX_PA_DATA) begin
        if (!keymux) begin
          lat_d[0] = wb;
        end
      end else if (idx == IDX_PB_DATA) begin
        lat_d[1] = wb;
      end else if (idx == IDX_PC_DATA) begin
        lat_d[2] = wb;
      end else if (idx == IDX_PD_DATA) begin
        lat_d[3] = (wb & ~ctl_q[0]) | (lat_q[3] & ctl_q[0]);
      end else if (idx == IDX_PE_DATA) begin
        lat_d[4] = wb;
      end else if (idx == IDX_PF_DATA) begin
        lat_d[5] = wb;
      end else if (idx == IDX_PG_DATA) begin
        lat_d[6] = wb;
      end else if (idx == IDX_PH_DATA) begin
        out_d[0] = wb;
      end else if (idx == IDX_PI_DATA) begin
        out_d[1] = wb;
      end else if (idx == IDX_PJ_DATA) begin
        out_d[2] = wb;
      end else if (idx == IDX_PA_DIR) begin
        dir_d[0] = wb;
      end else if (idx == IDX_PB_DIR) begin
        dir_d[1] = wb;
      end else if (idx == IDX_PC_DIR) begin
        dir_d[2] = wb;
      end else if (idx == IDX_PD_DIR) begin
        dir_d[3] = (wb & ~ctl_q[0]) | (dir_q[3] & ctl_q[0]);
      end else if (idx == IDX_PE_DIR) begin
        dir_d[4] = wb;
      end else if (idx == IDX_PD_CTRL) begin
        ctl_d[0] = wb;
      end else if (idx == IDX_PE_CTRL) begin
        ctl_d[1] = wb;
      end else if (idx == IDX_PF_CTRL) begin
        ctl_d[2] = wb;
      end else if (idx == IDX_PG_CTRL) begin
        ctl_d[3] = wb;
      end else if (idx == IDX_PH_CTRL) begin
        ctl_d[4] = wb;
      end else if (idx == IDX_PI_CTRL) begin
        ctl_d[5] = wb;
      end else if (idx == IDX_PJ_CTRL) begin
        ctl_d[6] = wb;
      end else if (idx == IDX_KEY_CTRL) begin
        key_en_d = wb[KEY_ENABLE_BIT];
        edg_d = wb[EDGE_LINES-1:0];
      end else if (idx == IDX_SYS_OPT) begin
        opt_d = {wb[OPT_PULLUP_BIT], wb[OPT_STATUS_VIEW_BIT]};
      end
    end
  end

  // Reset clears direction, control and output-only data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q <= '{default: DIR_RST};
      out_q <= '{default: OUT_ONLY_RST};
      ctl_q <= '{default: CTRL_RST};
      edg_q <= EDGE_RST;
      key_en_q <= 1'h0;
      opt_q <= OPT_RST;
      ack_q <= 1'b0;
      dat_q <= DAT_RST;
    end else begin
      dir_q <= dir_d;
      out_q <= out_d;
      ctl_q <= ctl_d;
      edg_q <= edg_d;
      key_en_q <= key_en_d;
      opt_q <= opt_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // Ports A to G data latches keep their value through reset
  always_ff @(posedge clk_i) begin
    lat_q <= lat_d;
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // Keypad request
  assign keypad_irq_o = key_en_q && keypad_flag && !cond_code_mask_i;

  // Ports A and B: direction 1 drives the latch
  assign pin_a_o = lat_q[0] & dir_q[0];
  assign pin_a_oe_o = dir_q[0];
  assign pin_b_o = lat_q[1] & dir_q[1];
  assign pin_b_oe_o = dir_q[1];
  // Pull-ups of port A off on rising-edge lines
  assign pullup_a_o = ~{2'h0, edg_q};

  // Port C with SPI on bits 7:4 and serial unit on bits 3:2
  always_comb begin
    pin_c_o = lat_q[2] & dir_q[2];
    pin_c_oe_o = dir_q[2];
    if (spi_enable_i) begin
      pin_c_o[7:4] = spi_out_i;
      pin_c_oe_o[7:4] = spi_oe_i;
    end
    if (sci_enable_i) begin
      pin_c_o[3] = sci_tx_i;
      pin_c_oe_o[3] = 1'b1;
      pin_c_o[2] = 1'b0;
      pin_c_oe_o[2] = 1'b0;
    end
  end
  assign spi_in_o = pin_c_i[7:4];
  assign serial_receive_in_o = pin_c_i[2];
  assign pullup_c_o = {8{pullup_enable}};

  // Captures: E0, E2, C0, C1 feed captures one to four
  assign capture_inputs_o = {pin_c_i[1], pin_c_i[0], pin_e_i[2], pin_e_i[0]};

  // Port D: open-drain, released where the converter owns the pin
  assign adc_select_o = ctl_q[0];
  assign pin_d_o = 8'h00;
  assign pin_d_oe_o = dir_q[3] & ~lat_q[3] & ~ctl_q[0];

  // Port E: open-drain with timer, refresh and pulse functions
  assign e_sel = ctl_q[1] & PE_SPECIAL_MASK;
  assign e_special = {pulse_outputs_i, refresh_clk_i, compare_outputs_i[1], 1'b1,
                      compare_outputs_i[0], 1'b1};
  assign pin_e_o = 8'h00;
  assign pin_e_oe_o = (e_sel & ~e_special) | (~e_sel & dir_q[4] & ~lat_q[4]);

  // Ports F and G: inputs unless handed to the frontplane driver
  assign pin_f_o = lcd_frontplane_lines_i[7:0] & ctl_q[2];
  assign pin_f_oe_o = ctl_q[2];
  assign pin_g_o = lcd_frontplane_lines_i[15:8] & ctl_q[3];
  assign pin_g_oe_o = ctl_q[3];

  // Ports H, I, J: outputs from data or frontplane; J open-drain
  assign hij_h = (ctl_q[4] & lcd_frontplane_lines_i[23:16]) | (~ctl_q[4] & out_q[0]);
  assign hij_i = (ctl_q[5] & lcd_frontplane_lines_i[31:24]) | (~ctl_q[5] & out_q[1]);
  assign hij_j = (ctl_q[6] & lcd_frontplane_lines_i[39:32]) | (~ctl_q[6] & out_q[2]);
  assign pin_h_o = hij_h;
  assign pin_i_o = hij_i;
  assign pin_j_o = 8'h00;
  assign pin_j_oe_o = ~hij_j;

  property p_irq_cause;
    @(posedge clk_i) disable iff (rst_i)
      keypad_irq_o == (key_en_q && key_status != 8'h00 && !cond_code_mask_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("keypad request without cause");

  property p_reset_clears;
    @(posedge clk_i) rst_i |=> (dir_q[1] == DIR_RST && dir_q[3] == DIR_RST &&
      ctl_q[0] == CTRL_RST && out_q[0] == OUT_ONLY_RST && pin_h_o == 8'h00);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state");

  property p_reset_keeps_b;
    @(posedge clk_i) (rst_i && !$past(rst_i)) |=> lat_q[1] == $past(lat_q[1]);
  endproperty
  a_reset_keeps_b: assert property (p_reset_keeps_b) else $error("reset altered port B");

  property p_b_write_drive;
    @(posedge clk_i) disable iff (rst_i)
      (wr_en && idx == IDX_PB_DATA && dir_q[1] == 8'hFF) |=> pin_b_o == $past(wb);
  endproperty
  a_b_write_drive: assert property (p_b_write_drive) else $error("port B not driven");

  property p_b_input_float;
    @(posedge clk_i) disable iff (rst_i) (dir_q[1] == 8'h00) |-> pin_b_oe_o == 8'h00;
  endproperty
  a_b_input_float: assert property (p_b_input_float) else $error("input pin driven");

  property p_b_read;
    @(posedge clk_i) disable iff (rst_i)
      (rd_take && idx == IDX_PB_DATA) |=>
      dat_o[7:0] == ((($past(dir_q[1])) & $past(lat_q[1])) | (~$past(dir_q[1]) & $past(pin_b_i)));
  endproperty
  a_b_read: assert property (p_b_read) else $error("port B read wrong");

  property p_d_blocked;
    @(posedge clk_i) disable iff (rst_i)
      (rd_take && (idx == IDX_PD_DATA || idx == IDX_PD_DIR)) |=> (dat_o[7:0] & ctl_q[0]) == 8'h00;
  endproperty
  a_d_blocked: assert property (p_d_blocked) else $error("converter bit read nonzero");

  property p_open_drain;
    @(posedge clk_i) disable iff (rst_i)
      pin_d_o == 8'h00 && pin_e_o == 8'h00 && pin_j_o == 8'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin driven high");

  property p_spi_route;
    @(posedge clk_i) disable iff (rst_i)
      spi_enable_i |-> (pin_c_o[7:4] == spi_out_i && spi_in_o == pin_c_i[7:4]);
  endproperty
  a_spi_route: assert property (p_spi_route) else $error("SPI not routed");

  property p_pullup_c;
    @(posedge clk_i) disable iff (rst_i)
      (wr_en && idx == IDX_SYS_OPT) |=> pullup_c_o == {8{$past(wb[OPT_PULLUP_BIT])}};
  endproperty
  a_pullup_c: assert property (p_pullup_c) else $error("pull-ups do not follow bit");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) keypad_irq_o);
  c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_en && idx == IDX_PB_DATA);
  c_key_clear: cover property (@(posedge clk_i) disable iff (rst_i) key_clr_mask != 8'h00);
endmodule
`default_nettype wire

// [rtl/ppb_pkg.sv]
// Package with register map, field positions and reset values of the port bank
// Summary of operation
// - Interrupt needs enable, flag set, mask clear
// - Edge bits pick rising or falling, lines 0-5
// - Reset keeps port B latch, clears direction
// - Write with direction 0 only stores latch
// - Write with direction 1 drives latch out
// - Read with direction 0 returns pin level
// - Read with direction 1 returns latch
// - SPI enabled takes port C bits 4-7
// - Serial unit takes C2/C3; C0/C1 feed captures
// - Port C pull-ups follow pull-up enable bit
// - Port D control bit selects converter; reset clears
// - Converter pins block port D writes, read 0
// - Ports D and E outputs are open-drain
// - Port E control selects compare, refresh, pulse outputs
// - E0 and E2 always feed captures one, two
// - F/G inputs, H/I/J outputs, control selects LCD
// - Reset clears H, I, J data; A-G kept
// - Port J outputs are open-drain
// - Direction 1 output, 0 input; reset clears
// - Lines 6 and 7 always falling-edge
// - Input edges set status; flag is OR
// - Reset, clear-all or write-one clears status
package ppb_pkg;
  localparam int ADR_W = 7;
  localparam int IDX_W = 5;
  localparam logic [4:0] IDX_PA_DATA = 5'h00;
  localparam logic [4:0] IDX_PB_DATA = 5'h01;
  localparam logic [4:0] IDX_PC_DATA = 5'h02;
  localparam logic [4:0] IDX_PD_DATA = 5'h03;
  localparam logic [4:0] IDX_PA_DIR = 5'h04;
  localparam logic [4:0] IDX_PB_DIR = 5'h05;
  localparam logic [4:0] IDX_PC_DIR = 5'h06;
  localparam logic [4:0] IDX_PD_DIR = 5'h07;
  localparam logic [4:0] IDX_PE_DATA = 5'h0A;
  localparam logic [4:0] IDX_PE_DIR = 5'h0B;
  localparam logic [4:0] IDX_PE_CTRL = 5'h0C;
  localparam logic [4:0] IDX_PF_DATA = 5'h10;
  localparam logic [4:0] IDX_PF_CTRL = 5'h11;
  localparam logic [4:0] IDX_PG_DATA = 5'h12;
  localparam logic [4:0] IDX_PG_CTRL = 5'h13;
  localparam logic [4:0] IDX_PH_DATA = 5'h14;
  localparam logic [4:0] IDX_PH_CTRL = 5'h15;
  localparam logic [4:0] IDX_PI_DATA = 5'h16;
  localparam logic [4:0] IDX_PI_CTRL = 5'h17;
  localparam logic [4:0] IDX_PJ_DATA = 5'h18;
  localparam logic [4:0] IDX_PJ_CTRL = 5'h19;
  localparam logic [4:0] IDX_PD_CTRL = 5'h1A;
  localparam logic [4:0] IDX_KEY_CTRL = 5'h1B;
  localparam logic [4:0] IDX_SYS_OPT = 5'h1C;
  localparam int OPT_STATUS_VIEW_BIT = 0;
  localparam int OPT_PULLUP_BIT = 1;
  localparam int OPT_CLEAR_ALL_BIT = 2;
  localparam int KEY_ENABLE_BIT = 6;
  localparam int KEY_FLAG_BIT = 7;
  localparam int EDGE_LINES = 6;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OUT_ONLY_RST = 8'h00;
  localparam logic [5:0] EDGE_RST = 6'h00;
  localparam logic [1:0] OPT_RST = 2'h0;
  localparam logic [7:0] KEY_SYNC_RST = 8'hFF;
  localparam logic [1:0] KEY_ARM_RST = 2'h0;
  localparam logic [7:0] PE_SPECIAL_MASK = 8'hFA;
  localparam logic [31:0] DAT_RST = 32'h0000_0000;
endpackage

// [rtl/ppb_key_edge.sv]
// Keypad line synchroniser, edge detector and sticky status flags
`timescale 1ns/1ns
`default_nettype none
module ppb_key_edge
  import ppb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] line_i,
  input wire logic [7:0] enable_i,
  input wire logic [7:0] rise_sel_i,
  input wire logic clear_all_i,
  input wire logic [7:0] clear_mask_i,
  output logic [7:0] status_o
);
  logic [7:0] meta_q, sync_q, prev_q, flag_q, flag_d, hit;
  logic [1:0] arm_q;

  // Two-stage synchroniser, then one more stage for edge compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= KEY_SYNC_RST;
      sync_q <= KEY_SYNC_RST;
      prev_q <= KEY_SYNC_RST;
      arm_q <= KEY_ARM_RST;
      flag_q <= 8'h00;
    end else begin
      meta_q <= line_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
      arm_q <= {arm_q[0], 1'b1};
      flag_q <= flag_d;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_line
      always_comb begin
        // Rising when selected, else falling; only while line is an input
        hit[b] = arm_q[1] && enable_i[b] &&
                 (rise_sel_i[b] ? (sync_q[b] && !prev_q[b]) : (!sync_q[b] && prev_q[b]));
        // Set wins over either clear
        flag_d[b] = hit[b] || (flag_q[b] && !clear_mask_i[b] && !clear_all_i);
      end
    end
  endgenerate

  assign status_o = flag_q;

  property p_edge_sets;
    @(posedge clk_i) disable iff (rst_i) hit[0] |=> flag_q[0];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag");

  property p_clear_all;
    @(posedge clk_i) disable iff (rst_i) (clear_all_i && hit == 8'h00) |=> flag_q == 8'h00;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear-all left a flag");

  property p_no_edge_hold;
    @(posedge clk_i) disable iff (rst_i)
      (sync_q == prev_q && !clear_all_i && clear_mask_i == 8'h00) |=> flag_q == $past(flag_q);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold) else $error("flag changed without cause");

  c_edge: cover property (@(posedge clk_i) disable iff (rst_i) hit != 8'h00);
endmodule
`default_nettype wire

// [bench/ppb_pin_model.sv]
// Outside world of one 8-bit port: resolves each line from device drive and outside level
`timescale 1ns/1ns
`default_nettype none
module ppb_pin_model (
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] lvl_o
);
  // Driven lines follow the device; open-drain release shows the pull level
  assign lvl_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the port bank over Wishbone
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ppb_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mask = 0, spi_en = 0, sci_en = 0;
  logic sci_tx = 0, rfr = 0, ack, irq, rxd;
  logic [6:0] adr = 7'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0] spi_out = 4'h0, spi_oe = 4'h0, spi_in, cap;
  logic [1:0] cmp = 2'h0;
  logic [2:0] pwm = 3'h0;
  logic [39:0] lcd = 40'h0;
  logic [7:0] ext [7] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [7:0] drv [7], oe [7], lvl [7];
  logic [7:0] ph, pi, pj, pj_oe, pu_a, pu_c, adc;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  localparam logic [4:0] ZERO_IDX [13] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h0B, 5'h0C, 5'h11,
    5'h14, 5'h15, 5'h16, 5'h18, 5'h1A, 5'h1F};
  always #20 clk_i = ~clk_i;
  for (genvar k = 0; k < 7; k++) begin : g_pin
    ppb_pin_model M (.drv_i(drv[k]), .oe_i(oe[k]), .ext_i(ext[k]), .lvl_o(lvl[k]));
  end
  ppb_port_bank DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .pin_a_i(lvl[0]), .pin_a_o(drv[0]), .pin_a_oe_o(oe[0]),
    .pin_b_i(lvl[1]), .pin_b_o(drv[1]), .pin_b_oe_o(oe[1]),
    .pin_c_i(lvl[2]), .pin_c_o(drv[2]), .pin_c_oe_o(oe[2]),
    .pin_d_i(lvl[3]), .pin_d_o(drv[3]), .pin_d_oe_o(oe[3]),
    .pin_e_i(lvl[4]), .pin_e_o(drv[4]), .pin_e_oe_o(oe[4]),
    .pin_f_i(lvl[5]), .pin_f_o(drv[5]), .pin_f_oe_o(oe[5]),
    .pin_g_i(lvl[6]), .pin_g_o(drv[6]), .pin_g_oe_o(oe[6]),
    .pin_h_o(ph), .pin_i_o(pi), .pin_j_o(pj), .pin_j_oe_o(pj_oe), .pullup_a_o(pu_a),
    .pullup_c_o(pu_c), .cond_code_mask_i(mask), .keypad_irq_o(irq), .spi_enable_i(spi_en),
    .spi_out_i(spi_out), .spi_oe_i(spi_oe), .spi_in_o(spi_in), .sci_enable_i(sci_en),
    .sci_tx_i(sci_tx), .serial_receive_in_o(rxd), .capture_inputs_o(cap),
    .compare_outputs_i(cmp), .refresh_clk_i(rfr), .pulse_outputs_i(pwm),
    .adc_select_o(adc), .lcd_frontplane_lines_i(lcd));
  task print_verdict;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict;
    end
  end
  task automatic bus(input logic w, input logic [4:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'h0}; wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'h1);
    q = rdat[7:0];
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk_i);
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rd(input string s, input logic [4:0] i, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(s, e, q);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    wait_n(8);
    rst_i <= 0;
    wait_n(1);
    foreach (ZERO_IDX[k]) rd("reset reg", ZERO_IDX[k], 8'h00);
    chk("pullup c", 8'h00, pu_c);
    $display("test reset done");
    wr(IDX_PB_DATA, 8'hA5);
    ext[1] <= 8'h3C;
    wait_n(1);
    chk("b oe", 8'h00, oe[1]);
    rd("b pin read", IDX_PB_DATA, 8'h3C);
    wr(IDX_PB_DIR, 8'hF0);
    chk("b oe", 8'hF0, oe[1]);
    chk("b out", 8'hA0, drv[1]);
    rd("b mixed read", IDX_PB_DATA, 8'hAC);
    rst_i <= 1;
    wait_n(2);
    rst_i <= 0;
    wait_n(1);
    rd("b dir", IDX_PB_DIR, 8'h00);
    wr(IDX_PB_DIR, 8'hFF);
    rd("b latch kept", IDX_PB_DATA, 8'hA5);
    $display("test port b done");
    wr(IDX_PD_CTRL, 8'h0F);
    chk("adc sel", 8'h0F, adc);
    wr(IDX_PD_DIR, 8'hFF);
    rd("d dir", IDX_PD_DIR, 8'hF0);
    wr(IDX_PD_DATA, 8'h55);
    rd("d data", IDX_PD_DATA, 8'h50);
    chk("d out", 8'h00, drv[3]);
    chk("d oe", 8'hA0, oe[3]);
    $display("test port d done");
    wr(IDX_SYS_OPT, 8'h02);
    chk("pullup c", 8'hFF, pu_c);
    spi_en <= 1; spi_out <= 4'hA; spi_oe <= 4'hF; sci_en <= 1; sci_tx <= 1;
    ext[2] <= 8'h06; ext[4] <= 8'h05; // C0, C1, E0, E2 kept as inputs
    wait_n(2);
    chk("c out", 8'hA8, drv[2]);
    chk("c oe", 8'hF8, oe[2]);
    chk("spi in", 8'h0A, {4'h0, spi_in});
    chk("rx in", 8'h01, {7'h0, rxd});
    chk("captures", 8'h0B, {4'h0, cap});
    $display("test port c done");
    wr(IDX_PH_DATA, 8'h5A);
    chk("h out", 8'h5A, ph);
    lcd <= 40'h00_00C3_0000;
    wr(IDX_PH_CTRL, 8'hF0);
    chk("h lcd", 8'hCA, ph);
    wr(IDX_PJ_DATA, 8'h0F);
    chk("j out", 8'h00, pj);
    chk("j oe", 8'hF0, pj_oe);
    chk("f oe", 8'h00, oe[5]);
    wr(IDX_PI_DATA, 8'h3C);
    chk("i out", 8'h3C, pi);
    cmp <= 2'h1;
    rfr <= 1;
    pwm <= 3'h2;
    wr(IDX_PE_CTRL, 8'hFF);
    chk("e oe", 8'hA8, oe[4]);
    chk("captures e", 8'h0B, {4'h0, cap});
    $display("test ports h j done");
    wr(IDX_KEY_CTRL, 8'h41);
    chk("pullup a", 8'hFE, pu_a);
    ext[0] <= 8'h7F;
    wait_n(6);
    chk("irq line7", 8'h01, {7'h0, irq});
    rd("key ctrl", IDX_KEY_CTRL, 8'hC1);
    mask <= 1;
    wait_n(2);
    chk("irq masked", 8'h00, {7'h0, irq});
    mask <= 0;
    wr(IDX_SYS_OPT, 8'h06);
    chk("irq clear all", 8'h00, {7'h0, irq});
    ext[0] <= 8'h7E;
    wait_n(6);
    chk("irq fall line0", 8'h00, {7'h0, irq});
    ext[0] <= 8'h7F;
    wait_n(6);
    chk("irq rise line0", 8'h01, {7'h0, irq});
    wr(IDX_SYS_OPT, 8'h03);
    rd("status", IDX_PA_DATA, 8'h01);
    wr(IDX_PA_DATA, 8'h01);
    rd("status cleared", IDX_PA_DATA, 8'h00);
    wr(IDX_PA_DIR, 8'h40);
    ext[0] <= 8'h3F;
    wait_n(6);
    rd("output line", IDX_PA_DATA, 8'h00);
    $display("test keypad done");
    print_verdict;
  end
endmodule
`default_nettype wire
